// *** core/tsp_i2c_phy.sv ***
`timescale 1ns/100ps
`default_nettype none
module tsp_i2c_phy import tsp_pkg::*; (
	input  wire logic core_clk,
	input  wire logic reset_n,
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe,
	tsp_ser_if.phy    ser
);
	typedef struct packed {
		tsp_phy_st_t st;
		logic [3:0]  cnt;
		logic [7:0]  sh;
		logic        is_addr;
		logic        rw;
		logic        oe;
		logic        scl_q;
		logic        sda_q;
	} tsp_phy_s_t;

	tsp_phy_s_t s_r, s_nxt;
	logic       rise;
	logic       fall;

	// Open drain: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe  = s_r.oe;
	assign ser.byte_in = s_r.sh;

	// ************************************************************
	// Bit engine, bit timing from serial clock edges, start and stop from data edges
	// ************************************************************
	always_comb begin
		s_nxt = s_r;
		ser.start = 1'b0;
		ser.stop = 1'b0;
		ser.addr_vld = 1'b0;
		ser.rx_vld = 1'b0;
		ser.tx_take = 1'b0;
		s_nxt.scl_q = scl_in;
		s_nxt.sda_q = sda_in;
		rise = ~s_r.scl_q & scl_in;
		fall = s_r.scl_q & ~scl_in;
		if (s_r.scl_q & scl_in & s_r.sda_q & ~sda_in) begin
			ser.start = 1'b1;  // Start or repeated start
			s_nxt.st = PH_RX;
			s_nxt.cnt = 4'h0;
			s_nxt.is_addr = 1'b1;
			s_nxt.rw = 1'b0;
			s_nxt.oe = 1'b0;
		end else if (s_r.scl_q & scl_in & ~s_r.sda_q & sda_in) begin
			ser.stop = 1'b1;
			s_nxt.st = PH_IDLE;
			s_nxt.oe = 1'b0;
		end else begin
			case (s_r.st)
				PH_RX: begin
					if (rise) begin
						s_nxt.sh = {s_r.sh[6:0], sda_in};
						s_nxt.cnt = s_r.cnt + 4'h1;
					end else if (fall && s_r.cnt == 4'h8) begin
						ser.addr_vld = s_r.is_addr;
						ser.rx_vld = ~s_r.is_addr;
						if (ser.ack_ok) begin
							s_nxt.st = PH_ACKW;
							s_nxt.oe = 1'b1;
							if (s_r.is_addr)
								s_nxt.rw = s_r.sh[0];
						end else begin
							s_nxt.st = PH_IDLE;
						end
					end
				end
				PH_ACKW: begin
					if (fall) begin
						s_nxt.is_addr = 1'b0;
						s_nxt.cnt = 4'h0;
						if (s_r.rw) begin
							ser.tx_take = 1'b1;
							s_nxt.sh = ser.tx_byte;
							s_nxt.oe = ~ser.tx_byte[7];
							s_nxt.st = PH_TX;
						end else begin
							s_nxt.oe = 1'b0;
							s_nxt.st = PH_RX;
						end
					end
				end
				PH_TX: begin
					if (rise) begin
						s_nxt.cnt = s_r.cnt + 4'h1;
					end else if (fall) begin
						if (s_r.cnt == 4'h8) begin
							s_nxt.oe = 1'b0;
							s_nxt.st = PH_ACKR;
						end else begin
							s_nxt.sh = {s_r.sh[6:0], 1'b0};
							s_nxt.oe = ~s_r.sh[6];
						end
					end
				end
				PH_ACKR: begin
					if (rise) begin
						if (sda_in)
							s_nxt.st = PH_IDLE;  // Host refused, end of read
						else
							s_nxt.cnt = 4'h9;
					end else if (fall && s_r.cnt == 4'h9) begin
						ser.tx_take = 1'b1;
						s_nxt.sh = ser.tx_byte;
						s_nxt.oe = ~ser.tx_byte[7];
						s_nxt.cnt = 4'h0;
						s_nxt.st = PH_TX;
					end
				end
				default: begin
					s_nxt.st = PH_IDLE;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_r <= '0;
			s_r.scl_q <= 1'b1;
			s_r.sda_q <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule : tsp_i2c_phy
`default_nettype wire

// *** core/tsp_pkg.sv ***
`default_nettype none
package tsp_pkg;
	// ************************************************************
	// Clock and conversion timing
	// ************************************************************
	localparam int CORE_CLK_MHZ    = 20;
	localparam int CONV_PERIOD_US  = 1000;
	localparam int CONV_CYCLES_DEF = CONV_PERIOD_US * CORE_CLK_MHZ;

	// ************************************************************
	// Serial bus address groups (upper four bits of 7-bit address) and broadcast codes (lower three bits)
	// ************************************************************
	localparam logic [3:0] SENS_GRP  = 4'h3;
	localparam logic [3:0] STORE_GRP = 4'hA;
	localparam logic [3:0] BCAST_GRP = 4'h6;
	localparam logic [2:0] BC_WP_CLR = 3'h4;
	localparam logic [2:0] BC_PAGE0  = 3'h6;
	localparam logic [2:0] BC_PAGE1  = 3'h7;

	// ************************************************************
	// Sensor register pointers and fields
	// ************************************************************
	localparam logic [7:0]  PTR_CAP       = 8'h00;
	localparam logic [7:0]  PTR_CFG       = 8'h01;
	localparam logic [7:0]  PTR_HIGH      = 8'h02;
	localparam logic [7:0]  PTR_CRIT      = 8'h03;
	localparam logic [7:0]  PTR_HYST      = 8'h04;
	localparam logic [7:0]  PTR_TEMP      = 8'h05;
	localparam int          CFG_RES_LSB   = 2;
	localparam int          CFG_EN_BIT    = 4;
	localparam int          CFG_CLR_BIT   = 5;
	localparam logic [4:0]  CFG_RST       = 5'h14;
	localparam logic [15:0] HLIM_RST      = 16'h0500;
	localparam logic [15:0] CLIM_RST      = 16'h05F0;
	localparam logic [15:0] HYST_RST      = 16'h0018;

	// ************************************************************
	// Presence-detect store layout
	// ************************************************************
	localparam int         STORE_BYTES = 512;
	localparam logic [8:0] RSV_LO      = 9'h100;
	localparam logic [8:0] RSV_HI      = 9'h13F;
	localparam logic [1:0] USER_BLK    = 2'h3;

	// ************************************************************
	// Register bus map
	// ************************************************************
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_INT_STAT = 8'h04;
	localparam logic [7:0] REG_INT_MASK = 8'h08;
	localparam logic [7:0] REG_STATE    = 8'h0C;
	localparam int         INT_ALERT    = 0;
	localparam int         INT_WRITE    = 1;
	localparam int         INT_WP       = 2;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;

	typedef enum logic [1:0] {
		MODE_INTR = 2'b00,
		MODE_COMP = 2'b01,
		MODE_CRIT = 2'b10
	} tsp_mode_t;

	typedef enum logic [1:0] {
		SEL_NONE  = 2'b00,
		SEL_SENS  = 2'b01,
		SEL_STORE = 2'b10,
		SEL_BCAST = 2'b11
	} tsp_sel_t;

	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_RX   = 3'b001,
		PH_ACKW = 3'b010,
		PH_TX   = 3'b011,
		PH_ACKR = 3'b100
	} tsp_phy_st_t;
endpackage : tsp_pkg
`default_nettype wire

// *** core/tsp_ser_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface tsp_ser_if;
	logic       start;
	logic       stop;
	logic       addr_vld;
	logic       rx_vld;
	logic [7:0] byte_in;
	logic       ack_ok;
	logic       tx_take;
	logic [7:0] tx_byte;

	modport phy  (output start, stop, addr_vld, rx_vld, byte_in, tx_take,
	              input ack_ok, tx_byte);
	modport core (input start, stop, addr_vld, rx_vld, byte_in, tx_take,
	              output ack_ok, tx_byte);
endinterface : tsp_ser_if
`default_nettype wire

// *** core/tsp_thermal_store.sv ***
`timescale 1ns/100ps
`default_nettype none
module tsp_thermal_store import tsp_pkg::*; #(
	parameter int CONV_CYCLES = CONV_CYCLES_DEF
) (
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	output logic             event_alert_out,
	output logic             event_alert_oe,
	input  wire logic [2:0]  slave_addr_select,
	input  wire logic [15:0] temp_sample,
	input  wire logic        backup_ready_status,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             irq
);
	typedef struct packed {
		tsp_sel_t    sel;
		logic        first;
		logic        hi_byte;
		logic [7:0]  ptr;
		logic [7:0]  wbuf;
		logic [7:0]  sa;
		logic        page;
		logic [3:0]  wp;
		logic [15:0] conv;
		logic [15:0] temp;
		logic [4:0]  cfg;
		logic [15:0] hlim;
		logic [15:0] clim;
		logic [15:0] hyst;
		logic        latch;
		logic        crit_hold;
		logic        hot_q;
		logic        alert_q;
		logic        oe;
		logic        bk;
		logic [2:0]  ist;
		logic [2:0]  imask;
		logic        aw_got;
		logic [7:0]  aw_a;
		logic        w_got;
		logic [31:0] wd;
		logic [3:0]  ws;
		logic        bv;
		logic [1:0]  br;
		logic        rv;
		logic [31:0] rd;
		logic [1:0]  rr;
	} tsp_core_s_t;

	tsp_core_s_t s_r, s_nxt;
	logic [7:0]  mem [0:STORE_BYTES-1];
	logic        mem_we;
	logic [8:0]  mem_wa;
	logic [7:0]  mem_wd;
	logic [8:0]  maddr;
	logic        rsv;
	logic [15:0] sword;
	logic [15:0] cool_lim;
	logic        hot;
	logic        crit;
	logic        act;
	logic [2:0]  bc;

	tsp_ser_if ser ();

	tsp_i2c_phy u_phy (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.scl_in   (scl_in),
		.sda_in   (sda_in),
		.sda_out  (sda_out),
		.sda_oe   (sda_oe),
		.ser      (ser.phy)
	);

	// ************************************************************
	// Decoders
	// ************************************************************
	function automatic logic axi_known(input logic [7:0] a);
		axi_known = (a == REG_CTRL) || (a == REG_INT_STAT) ||
		            (a == REG_INT_MASK) || (a == REG_STATE);
	endfunction : axi_known

	function automatic logic [15:0] sens_word(input logic [7:0] p, input tsp_core_s_t c);
		case (p)
			PTR_CAP:  sens_word = {8'h00, 3'h0, c.cfg[CFG_RES_LSB+:2], 3'h1};
			PTR_CFG:  sens_word = {8'h00, 1'b0, c.latch, 1'b0, c.cfg};
			PTR_HIGH: sens_word = c.hlim;
			PTR_CRIT: sens_word = c.clim;
			PTR_HYST: sens_word = c.hyst;
			PTR_TEMP: sens_word = c.temp;
			default:  sens_word = 16'h0000;
		endcase
	endfunction : sens_word

	// ************************************************************
	// Outputs
	// ************************************************************
	assign event_alert_out = 1'b0;
	assign event_alert_oe  = s_r.oe;
	assign irq             = |(s_r.ist & s_r.imask);
	assign s_axi_awready   = ~s_r.aw_got & ~s_r.bv;
	assign s_axi_wready    = ~s_r.w_got & ~s_r.bv;
	assign s_axi_bvalid    = s_r.bv;
	assign s_axi_bresp     = s_r.br;
	assign s_axi_arready   = ~s_r.rv;
	assign s_axi_rvalid    = s_r.rv;
	assign s_axi_rdata     = s_r.rd;
	assign s_axi_rresp     = s_r.rr;

	// Store address, reserved range forced to zero
	assign maddr    = {s_r.page, s_r.sa};
	assign rsv      = (maddr >= RSV_LO) && (maddr <= RSV_HI);
	assign sword    = sens_word(s_r.ptr, s_r);
	assign cool_lim = s_r.clim - s_r.hyst;
	assign hot      = $signed(s_r.temp) > $signed(s_r.hlim);
	assign crit     = $signed(s_r.temp) > $signed(s_r.clim);
	assign bc       = ser.byte_in[3:1];

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always_comb begin
		s_nxt = s_r;
		mem_we = 1'b0;
		mem_wa = maddr;
		mem_wd = ser.byte_in;
		act = 1'b0;
		ser.ack_ok = 1'b0;
		ser.tx_byte = 8'h00;

		// Read data toward the serial host
		if (s_r.sel == SEL_SENS)
			ser.tx_byte = s_r.hi_byte ? sword[15:8] : sword[7:0];
		else if (s_r.sel == SEL_STORE)
			ser.tx_byte = rsv ? 8'h00 : mem[maddr];

		// Periodic refresh of the temperature register
		if (s_r.conv == 16'(CONV_CYCLES - 1)) begin
			s_nxt.conv = 16'h0000;
			s_nxt.temp = temp_sample & (16'hFFFF << (2'd3 - s_r.cfg[CFG_RES_LSB+:2]));
		end else begin
			s_nxt.conv = s_r.conv + 16'h0001;
		end

		// Address phase
		if (ser.addr_vld) begin
			if (ser.byte_in[7:1] == {SENS_GRP, slave_addr_select}) begin
				ser.ack_ok = 1'b1;
				s_nxt.sel = SEL_SENS;
				s_nxt.hi_byte = 1'b1;
				s_nxt.first = ~ser.byte_in[0];
			end else if (ser.byte_in[7:1] == {STORE_GRP, slave_addr_select}) begin
				ser.ack_ok = 1'b1;
				s_nxt.sel = SEL_STORE;
				s_nxt.first = ~ser.byte_in[0];
			end else if (ser.byte_in[7:4] == BCAST_GRP && !ser.byte_in[0]) begin
				ser.ack_ok = 1'b1;
				s_nxt.sel = SEL_BCAST;
				if (!bc[2] && bc[1:0] != USER_BLK)
					s_nxt.wp[bc[1:0]] = 1'b1;
				else if (bc == BC_WP_CLR)
					s_nxt.wp = 4'h0;
				else if (bc == BC_PAGE0)
					s_nxt.page = 1'b0;
				else if (bc == BC_PAGE1)
					s_nxt.page = 1'b1;
			end else begin
				s_nxt.sel = SEL_NONE;
			end
		end

		// Written data bytes
		if (ser.rx_vld) begin
			ser.ack_ok = (s_r.sel != SEL_NONE);
			if (s_r.sel == SEL_SENS) begin
				if (s_r.first) begin
					s_nxt.ptr = ser.byte_in;
					s_nxt.first = 1'b0;
				end else if (s_r.hi_byte) begin
					s_nxt.wbuf = ser.byte_in;
					s_nxt.hi_byte = 1'b0;
				end else begin
					s_nxt.hi_byte = 1'b1;
					case (s_r.ptr)
						PTR_CFG: begin
							s_nxt.cfg = ser.byte_in[4:0];
							if (ser.byte_in[CFG_CLR_BIT])
								s_nxt.latch = 1'b0;
						end
						PTR_HIGH: s_nxt.hlim = {s_r.wbuf, ser.byte_in};
						PTR_CRIT: s_nxt.clim = {s_r.wbuf, ser.byte_in};
						PTR_HYST: s_nxt.hyst = {s_r.wbuf, ser.byte_in};
						default: ;
					endcase
				end
			end else if (s_r.sel == SEL_STORE) begin
				if (s_r.first) begin
					s_nxt.sa = ser.byte_in;
					s_nxt.first = 1'b0;
				end else begin
					s_nxt.sa = s_r.sa + 8'h01;
					// Protected blocks and reserved bytes drop the write
					if (!rsv && (maddr[8:7] == USER_BLK || !s_r.wp[maddr[8:7]])) begin
						mem_we = 1'b1;
						s_nxt.ist[INT_WRITE] = 1'b1;
					end
				end
			end
		end

		// Read byte consumed by the bit engine
		if (ser.tx_take) begin
			if (s_r.sel == SEL_SENS)
				s_nxt.hi_byte = ~s_r.hi_byte;
			else if (s_r.sel == SEL_STORE)
				s_nxt.sa = s_r.sa + 8'h01;
		end
		if (ser.start || ser.stop)
			s_nxt.sel = SEL_NONE;

		// Alert behaviour
		s_nxt.hot_q = hot;
		if (hot && !s_r.hot_q)
			s_nxt.latch = 1'b1;
		if (crit)
			s_nxt.crit_hold = 1'b1;
		else if ($signed(s_r.temp) < $signed(cool_lim))
			s_nxt.crit_hold = 1'b0;
		case (tsp_mode_t'(s_r.cfg[1:0]))
			MODE_INTR: act = s_r.latch | crit;
			MODE_COMP: act = hot | crit;
			MODE_CRIT: act = s_r.crit_hold;
			default:   act = hot | crit;
		endcase
		s_nxt.alert_q = act & s_r.cfg[CFG_EN_BIT];
		s_nxt.oe = s_nxt.alert_q | (s_r.bk & ~backup_ready_status);

		// Register bus write
		if (s_axi_awvalid && s_axi_awready) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.aw_a = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_nxt.w_got = 1'b1;
			s_nxt.wd = s_axi_wdata;
			s_nxt.ws = s_axi_wstrb;
		end
		if (s_r.aw_got && s_r.w_got) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bv = 1'b1;
			s_nxt.br = axi_known(s_r.aw_a) ? RESP_OKAY : RESP_SLVERR;
			if (s_r.ws[0]) begin
				case (s_r.aw_a)
					REG_CTRL:     s_nxt.bk = s_r.wd[0];
					REG_INT_STAT: s_nxt.ist = s_nxt.ist & ~s_r.wd[2:0];
					REG_INT_MASK: s_nxt.imask = s_r.wd[2:0];
					default: ;
				endcase
			end
		end
		if (s_r.bv && s_axi_bready)
			s_nxt.bv = 1'b0;

		// Register bus read
		if (s_axi_arvalid && !s_r.rv) begin
			s_nxt.rv = 1'b1;
			s_nxt.rr = axi_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr)
				REG_CTRL:     s_nxt.rd = {31'h0, s_r.bk};
				REG_INT_STAT: s_nxt.rd = {29'h0, s_r.ist};
				REG_INT_MASK: s_nxt.rd = {29'h0, s_r.imask};
				REG_STATE:    s_nxt.rd = {9'h0, s_r.page, s_r.wp, backup_ready_status,
				                          s_r.alert_q, s_r.temp};
				default:      s_nxt.rd = 32'h0;
			endcase
		end
		if (s_r.rv && s_axi_rready)
			s_nxt.rv = 1'b0;

		// Sticky events, set wins over clear
		if (s_nxt.alert_q && !s_r.alert_q)
			s_nxt.ist[INT_ALERT] = 1'b1;
		if (s_nxt.wp != s_r.wp)
			s_nxt.ist[INT_WP] = 1'b1;
		if (mem_we)
			s_nxt.ist[INT_WRITE] = 1'b1;
	end

	// ************************************************************
	// Storage
	// ************************************************************
	// State register
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_r <= '0;
			s_r.cfg <= CFG_RST;
			s_r.hlim <= HLIM_RST;
			s_r.clim <= CLIM_RST;
			s_r.hyst <= HYST_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Store array write port
	always_ff @(posedge core_clk) begin
		if (mem_we)
			mem[mem_wa] <= mem_wd;
	end
endmodule : tsp_thermal_store
`default_nettype wire

// *** test/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench import tsp_pkg::*; ;
	localparam int CONV = 16;
	localparam int T_UPD = 2 * CONV + 8;
	logic        core_clk, reset_n, bk_rdy, irq, scl, sda_low, sda_oe, sda_out, a_out, a_oe;
	logic        awv, awr, wv, wrd, bv, bre, arv, arr, rv, rre;
	logic [1:0]  br, rr;
	logic [2:0]  sa;
	logic [7:0]  awa, ara;
	logic [15:0] temp;
	logic [31:0] wd, rdat;
	int          n_mismatch, tests_run;
	wire logic   sda = !(sda_low || sda_oe);
	tsp_thermal_store #(.CONV_CYCLES(CONV)) dut (
		.core_clk(core_clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .event_alert_out(a_out), .event_alert_oe(a_oe),
		.slave_addr_select(sa), .temp_sample(temp), .backup_ready_status(bk_rdy),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rre), .irq(irq)
	);
	tsp_host_bfm host (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w, b;
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bre <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(negedge core_clk);
			aw = awv && awr;
			w = wv && wrd;
			b = bv && bre;
			if (b) chk(br, er);
			@(posedge core_clk);
			if (aw) awv <= 1'b0;
			if (w) wv <= 1'b0;
		end
		bre <= 1'b0;
		@(posedge core_clk);
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		logic ar, r;
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		r = 1'b0;
		while (!r) begin
			@(negedge core_clk);
			ar = arv && arr;
			r = rv && rre;
			d = rdat;
			if (r) chk(rr, er);
			@(posedge core_clk);
			if (ar) arv <= 1'b0;
		end
		rre <= 1'b0;
		@(posedge core_clk);
	endtask : axi_rd
	task automatic ser_wr(input logic [3:0] g, input logic [7:0] p, input logic [15:0] v,
			input int n);
		logic a;
		host.start();
		host.wr({g, sa, 1'b0}, a);
		host.wr(p, a);
		if (n == 2) host.wr(v[15:8], a);
		host.wr(v[7:0], a);
		host.stop();
	endtask : ser_wr
	task automatic ser_rd(input logic [3:0] g, input logic [7:0] p, input int n,
			output logic [15:0] v);
		logic a;
		v = 16'h0;
		host.start();
		host.wr({g, sa, 1'b0}, a);
		host.wr(p, a);
		host.start();
		host.wr({g, sa, 1'b1}, a);
		if (n == 2) host.rd(v[15:8], 1'b0);
		host.rd(v[7:0], 1'b1);
		host.stop();
	endtask : ser_rd
	task automatic bc(input logic [2:0] x);
		logic a;
		host.start();
		host.wr({BCAST_GRP, x, 1'b0}, a);
		host.stop();
		chk(a, 1'b1);
	endtask : bc
	task automatic t_step(input logic [15:0] t, input logic e);
		temp <= t;
		host.tick(T_UPD);
		@(negedge core_clk);
		chk(a_oe, e);
		@(posedge core_clk);
	endtask : t_step
	task automatic irq_is(input logic e);
		@(negedge core_clk);
		chk(irq, e);
		@(posedge core_clk);
	endtask : irq_is
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs();
		logic [31:0] d;
		axi_rd(REG_STATE, d, RESP_OKAY);
		chk(d[31:16], 16'h0002);
		chk({sda_out, a_out}, 2'h0);
		axi_rd(REG_CTRL, d, RESP_OKAY);
		chk(d, 32'h0);
		axi_rd(REG_INT_MASK, d, RESP_OKAY);
		chk(d, 32'h0);
		axi_rd(8'h10, d, RESP_SLVERR);
		chk(d, 32'h0);
		axi_wr(8'h20, 32'h1, RESP_SLVERR);
		axi_wr(REG_INT_MASK, 32'h1, RESP_OKAY);
	endtask : t_regs
	task automatic t_temp();
		logic [15:0] v;
		logic [31:0] d;
		logic        a;
		temp <= 16'h0197;
		for (int r = 0; r < 4; r++) begin
			ser_wr(SENS_GRP, PTR_CFG, 16'h0010 | 16'(r << 2), 2);
			host.tick(T_UPD);
			ser_rd(SENS_GRP, PTR_TEMP, 2, v);
			chk(v, 16'h0197 & (16'hFFFF << (3 - r)));
			ser_rd(SENS_GRP, PTR_CAP, 2, v);
			chk(v, 16'(r << 3) | 16'h0001);
		end
		ser_wr(SENS_GRP, PTR_CFG, 16'h0014, 2);
		host.tick(T_UPD);
		axi_rd(REG_STATE, d, RESP_OKAY);
		chk(d[15:0], 16'h0194);
		host.start();
		host.wr({SENS_GRP, ~sa, 1'b0}, a);
		host.stop();
		chk(a, 1'b0);
	endtask : t_temp
	task automatic t_alert();
		t_step(16'h0520, 1'b1);
		irq_is(1'b1);
		t_step(16'h0100, 1'b1);
		ser_wr(SENS_GRP, PTR_CFG, 16'h0034, 2);
		t_step(16'h0100, 1'b0);
		axi_wr(REG_INT_STAT, 32'h1, RESP_OKAY);
		irq_is(1'b0);
		ser_wr(SENS_GRP, PTR_CFG, 16'h0015, 2);
		t_step(16'h0520, 1'b1);
		t_step(16'h0100, 1'b0);
		ser_wr(SENS_GRP, PTR_CFG, 16'h0017, 2);
		t_step(16'h0520, 1'b1);
		t_step(16'h0100, 1'b0);
		ser_wr(SENS_GRP, PTR_CFG, 16'h0016, 2);
		t_step(16'h0520, 1'b0);
		t_step(16'h0600, 1'b1);
		t_step(16'h05E0, 1'b1);
		t_step(16'h05C0, 1'b0);
	endtask : t_alert
	task automatic t_backup();
		logic [31:0] d;
		axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
		bk_rdy <= 1'b0;
		t_step(16'h05C0, 1'b1);
		axi_rd(REG_STATE, d, RESP_OKAY);
		chk(d[17], 1'b0);
		bk_rdy <= 1'b1;
		t_step(16'h05C0, 1'b0);
	endtask : t_backup
	task automatic t_store();
		logic [15:0] v;
		logic [31:0] d;
		axi_wr(REG_INT_STAT, 32'h7, RESP_OKAY);
		bc(3'h7);
		bc(3'h3);
		ser_wr(STORE_GRP, 8'h80, 16'h005A, 1);
		ser_rd(STORE_GRP, 8'h80, 1, v);
		chk(v, 16'h005A);
		ser_wr(STORE_GRP, 8'h00, 16'h00FF, 1);
		ser_rd(STORE_GRP, 8'h00, 1, v);
		chk(v, 16'h0000);
		bc(3'h6);
		ser_wr(STORE_GRP, 8'h10, 16'h00A5, 1);
		sa <= 3'h2;
		bc(3'h0);
		sa <= 3'h5;
		ser_wr(STORE_GRP, 8'h10, 16'h003C, 1);
		ser_rd(STORE_GRP, 8'h10, 1, v);
		chk(v, 16'h00A5);
		axi_rd(REG_STATE, d, RESP_OKAY);
		chk(d[22:18], 5'h01);
		bc(3'h4);
		ser_wr(STORE_GRP, 8'h10, 16'h003C, 1);
		ser_rd(STORE_GRP, 8'h10, 1, v);
		chk(v, 16'h003C);
		axi_rd(REG_INT_STAT, d, RESP_OKAY);
		chk(d[2:1], 2'h3);
		irq_is(1'b0);
	endtask : t_store
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	// Clock, 50 ns period
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = !core_clk;
	end
	// Watchdog, well past the expected run
	initial begin
		#4000000;
		n_mismatch++;
		test_done();
	end
	// Main sequence
	initial begin
		{reset_n, awv, wv, bre, arv, rre, awa, ara, wd} = '0;
		sa = 3'h5;
		temp = 16'h0100;
		bk_rdy = 1'b1;
		n_mismatch = 0;
		tests_run = 0;
		repeat (8) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		t_regs();
		t_temp();
		t_alert();
		t_backup();
		t_store();
		test_done();
	end
endmodule : testbench
`default_nettype wire

// *** test/tsp_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
module tsp_chk import tsp_pkg::*; #(
	parameter int CONV_CYCLES = 16
) (
	input wire logic        core_clk,
	input wire logic        reset_n,
	input wire logic        scl_in,
	input wire logic        sda_oe,
	input wire logic        event_alert_out,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        irq
);
	// ****************************************
	// Pin and register bus relations
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// Both write channels taken at one edge
	sequence s_wr_go;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// Answer two edges later, not one
	sequence s_b_late;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	property p_alert_od; event_alert_out == 1'b0; endproperty
	a_alert_od: assert property (p_alert_od) else $error("alert pin driven high");
	property p_sda_edge; $changed(sda_oe) |-> !scl_in; endproperty
	a_sda_edge: assert property (p_sda_edge) else $error("data moved with clock high");
	property p_wr_lat; s_wr_go |=> s_b_late; endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer off time");
	property p_w_hold; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_w_hold: assert property (p_w_hold) else $error("write taken while answer pending");
	property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	a_b_drop: assert property (p_b_drop) else $error("write answer not released");
	property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer off time");
	property p_rd_bad;
		s_axi_arvalid && s_axi_arready && s_axi_araddr > REG_STATE
			|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
	endproperty
	a_rd_bad: assert property (p_rd_bad) else $error("unmapped read not refused");
	property p_irq_fall; $fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without a write");
endmodule : tsp_chk
bind tsp_thermal_store tsp_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
	.core_clk(core_clk), .reset_n(reset_n), .scl_in(scl_in), .sda_oe(sda_oe),
	.event_alert_out(event_alert_out), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .irq(irq)
);
`default_nettype wire

// *** test/tsp_host_bfm.sv ***
`timescale 1ns/100ps
`default_nettype none
module tsp_host_bfm (
	input  wire logic core_clk,
	input  wire logic sda,
	output var logic  scl,
	output var logic  sda_low
);
	// Both lines released until the first frame
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick
	// One bit in 20 core clocks, 1 MHz serial rate
	task automatic bit_x(input logic b, output logic r);
		sda_low <= !b;
		tick(5);
		scl <= 1'b1;
		tick(5);
		r = sda;
		tick(5);
		scl <= 1'b0;
		tick(5);
	endtask : bit_x
	// Start or repeated start
	task automatic start();
		sda_low <= 1'b0;
		tick(5);
		scl <= 1'b1;
		tick(5);
		sda_low <= 1'b1;
		tick(5);
		scl <= 1'b0;
		tick(5);
	endtask : start
	task automatic stop();
		sda_low <= 1'b1;
		tick(5);
		scl <= 1'b1;
		tick(5);
		sda_low <= 1'b0;
		tick(5);
	endtask : stop
	// Byte out, msb first, then the slave's ack
	task automatic wr(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r);
		bit_x(1'b1, r);
		ack = !r;
	endtask : wr
	task automatic rd(output logic [7:0] d, input logic last);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
		bit_x(last, r);
	endtask : rd
endmodule : tsp_host_bfm
`default_nettype wire
